/* File: src/watchdog_timer.v */
// Watchdog timer with AXI4-Lite register access and a system reset request output.
// Assumes the system reset logic re-asserts RST_N or its own domain from WDOG_RESET_REQ.
// Assumes every register field travels in byte lane 0 of the write data.
//
// Function
// - Watchdog runs after every reset; software must disable it explicitly.
// - Thirteen-bit prescaler feeds an eight-bit down-counter.
// - Prescaler advances on the shared timer base clock tick.
// - Counter decrements on a tap from prescaler stages 4 to 11; the top stage is not used.
// - Tap code 0 divides by 32, doubling up to 4096 at code 7.
// - Tick at zero signals underflow and reloads from autoload value.
// - Every autoload clears the prescaler; reload 0 to FF is accepted.
// - Counter is never written directly, only loaded from the reload value.
// - Feed is A5 to first port then 5A to second port.
// - Correct first write with wrong second value resets immediately.
// - Any other register access between feed writes causes a watchdog reset.
// - Control tap and run writes stay pending until a valid feed completes; a flag clear acts at once.
// - Reset values give a running watchdog with 4 times 4096 periods.
// - External reset sets run, clears reload, flag, prescaler, picks top tap, autoloads.
// - Underflow together with external reset leaves the timeout flag clear.
// - Underflow autoloads, sets flag, keeps settings, then resets the device.
// - Timeout flag is readable and software-clearable.
// - Control bits 7..5 tap reset ones, bit 2 run reset one, bit 1 flag.
// - Timeout is osc period times base prescale times tap divisor times reload+1.
// - Two system prescale bits pick osc/4, /16, /64; 11 reserved.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.vh"

module watchdog_timer #(
   // Prescaler width and reset request length in clocks
   parameter PRESC_W = `WD_PRESC_W,
   parameter [3:0] PULSE_LEN = `WD_RST_PULSE
) (
   // Clock and reset
   input wire CLK,
   input wire RST_N,
   // AXI4-Lite write address
   input wire [11:0] S_AXI_AWADDR,
   input wire [2:0] S_AXI_AWPROT,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   // AXI4-Lite write data
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   // AXI4-Lite write response
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   // AXI4-Lite read address
   input wire [11:0] S_AXI_ARADDR,
   input wire [2:0] S_AXI_ARPROT,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   // AXI4-Lite read data
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Reset request to the system
   output reg WDOG_RESET_REQ
);
   // Reset synchroniser
   reg rst_meta_q;
   reg rst_sync_q;
   wire rst_n;

   // Only the second flop feeds the logic; the first may go metastable on release
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // Watchdog state
   reg [2:0] tap_q;
   reg run_q;
   reg tof_q;
   reg [7:0] pend_ctrl_q;
   reg [7:0] reload_q;
   reg [1:0] tprescale_q;
   reg [PRESC_W-1:0] presc_q;
   reg [7:0] count_q;
   reg tap_prev_q;
   reg feed_armed_q;
   reg [3:0] pulse_q;

   // Bus capture state
   reg [11:0] aw_addr_q;
   reg aw_full_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_full_q;

   wire base_tick;

   // Bus response codes
   localparam RESP_OKAY = 2'b00;
   localparam RESP_SLVERR = 2'b10;

   wdog_tick_div u_tick (
      .clk(CLK),
      .rst_n(rst_n),
      .prescale_sel(tprescale_q),
      .tick(base_tick)
   );

   // A channel is accepted only while its holding slot is empty and no response waits
   assign S_AXI_AWREADY = !aw_full_q && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_full_q && !S_AXI_BVALID;
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
   wire w_take = S_AXI_WVALID && S_AXI_WREADY;
   wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
   wire aw_have = aw_full_q || aw_take;
   wire w_have = w_full_q || w_take;
   wire wr_go = aw_have && w_have;
   wire [11:0] wr_addr = aw_full_q ? aw_addr_q : S_AXI_AWADDR;
   wire [31:0] wr_data = w_full_q ? w_data_q : S_AXI_WDATA;
   wire [3:0] wr_strb = w_full_q ? w_strb_q : S_AXI_WSTRB;
   wire wr_lane0 = wr_strb[0];
   wire [7:0] wr_byte = wr_data[7:0];

   // Write decode
   reg wr_ok;
   reg wr_ctrl;
   reg wr_reload;
   reg wr_feed1;
   reg wr_feed2;
   reg wr_syscfg;

   always @* begin
      wr_ok = 1'b1;
      wr_ctrl = 1'b0;
      wr_reload = 1'b0;
      wr_feed1 = 1'b0;
      wr_feed2 = 1'b0;
      wr_syscfg = 1'b0;
      if (wr_addr == `WD_OFS_CONTROL) begin
         wr_ctrl = wr_go && wr_lane0;
      end else if (wr_addr == `WD_OFS_RELOAD) begin
         wr_reload = wr_go && wr_lane0;
      end else if (wr_addr == `WD_OFS_FEED1) begin
         wr_feed1 = wr_go && wr_lane0;
      end else if (wr_addr == `WD_OFS_FEED2) begin
         wr_feed2 = wr_go && wr_lane0;
      end else if (wr_addr == `WD_OFS_SYSCFG) begin
         wr_syscfg = wr_go && wr_lane0;
      end else if (wr_addr == `WD_OFS_STATUS) begin
         // Status is read-only: the write is answered but changes nothing
         wr_ok = 1'b1;
      end else begin
         wr_ok = 1'b0;
      end
   end

   // Feed sequence
   // Reads count as register accesses too, so a poll between the feed writes breaks it
   wire any_access = wr_go || ar_take;
   wire feed1_good = wr_feed1 && (wr_byte == `WD_FEED1_KEY);
   wire feed_done = feed_armed_q && wr_feed2 && (wr_byte == `WD_FEED2_KEY);
   wire feed_bad_val = feed_armed_q && wr_feed2 && (wr_byte != `WD_FEED2_KEY);
   wire feed_bad_acc = feed_armed_q && any_access && !wr_feed2;
   wire feed_fail = feed_bad_val || feed_bad_acc;

   // Prescaler tap and underflow
   wire [2:0] tap_eff = feed_done ? pend_ctrl_q[`WD_TAP_MSB:`WD_TAP_LSB] : tap_q;
   wire tap_bit = presc_q[`WD_TAP_BASE + tap_q];
   // Decrement on the tap's falling edge, the carry into the next stage: a rising
   // edge would come half a divisor after a cleared prescaler and shorten the timeout
   wire tap_fall = !tap_bit && tap_prev_q;
   wire dec_tick = tap_fall && run_q;
   wire underflow = dec_tick && (count_q == 8'h00);
   wire wd_fire = underflow || feed_fail;

   // Software-written registers; control writes land in the pending copy, the flag clear acts below
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pend_ctrl_q <= `WD_CONTROL_RST;
         reload_q <= `WD_RELOAD_RST;
         tprescale_q <= 2'b00;
      end else begin
         if (wr_ctrl) begin
            pend_ctrl_q <= wr_byte;
         end
         if (wr_reload) begin
            reload_q <= wr_byte;
         end
         if (wr_syscfg) begin
            tprescale_q <= {wr_byte[`WD_PT_HI_BIT], wr_byte[`WD_PT_LO_BIT]};
         end
      end
   end

   // Active settings, prescaler and main counter
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         tap_q <= 3'b111;
         run_q <= 1'b1;
         presc_q <= {PRESC_W{1'b0}};
         count_q <= `WD_RELOAD_RST;
         tap_prev_q <= 1'b0;
      end else begin
         if (feed_done) begin
            tap_q <= tap_eff;
            run_q <= pend_ctrl_q[`WD_RUN_BIT];
         end
         if (feed_done || underflow) begin
            count_q <= reload_q;
            presc_q <= {PRESC_W{1'b0}};
            tap_prev_q <= 1'b0;
         end else begin
            if (base_tick && run_q) begin
               presc_q <= presc_q + 1'b1;
            end
            tap_prev_q <= tap_bit;
            if (dec_tick) begin
               count_q <= count_q - 8'd1;
            end
         end
      end
   end

   // Feed arming: only the very next register access may complete the feed
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         feed_armed_q <= 1'b0;
      end else if (feed_done || feed_fail) begin
         feed_armed_q <= 1'b0;
      end else if (feed1_good) begin
         feed_armed_q <= 1'b1;
      end else if (any_access) begin
         feed_armed_q <= 1'b0;
      end
   end

   // Timeout flag: external reset clears it even if an underflow lands at the same time
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         tof_q <= 1'b0;
      end else if (underflow) begin
         // Hardware set wins over a software clear arriving the same cycle
         tof_q <= 1'b1;
      end else if (wr_ctrl && !wr_byte[`WD_TOF_BIT]) begin
         tof_q <= 1'b0;
      end
   end

   // Reset request, stretched so slow reset logic cannot miss it
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pulse_q <= 4'h0;
         WDOG_RESET_REQ <= 1'b0;
      end else begin
         if (wd_fire) begin
            pulse_q <= PULSE_LEN;
         end else if (pulse_q != 4'h0) begin
            pulse_q <= pulse_q - 4'd1;
         end
         WDOG_RESET_REQ <= wd_fire || (pulse_q > 4'd1);
      end
   end

   // Write channel bookkeeping and response
   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         aw_addr_q <= 12'h000;
         aw_full_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         w_full_q <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= 2'b00;
      end else begin
         if (wr_go) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else begin
            if (aw_take) begin
               aw_addr_q <= S_AXI_AWADDR;
               aw_full_q <= 1'b1;
            end
            if (w_take) begin
               w_data_q <= S_AXI_WDATA;
               w_strb_q <= S_AXI_WSTRB;
               w_full_q <= 1'b1;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
               S_AXI_BVALID <= 1'b0;
            end
         end
      end
   end

   // Read decode: control shows the active settings; the pending copy is seen in status
   reg [31:0] rd_word;
   reg rd_ok;

   always @* begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      if (S_AXI_ARADDR == `WD_OFS_CONTROL) begin
         rd_word[7:0] = {tap_q, 2'b00, run_q, tof_q, 1'b0};
      end else if (S_AXI_ARADDR == `WD_OFS_RELOAD) begin
         rd_word[7:0] = reload_q;
      end else if (S_AXI_ARADDR == `WD_OFS_FEED1) begin
         // Feed ports are write-only and read back zero
         rd_word = 32'h0000_0000;
      end else if (S_AXI_ARADDR == `WD_OFS_FEED2) begin
         rd_word = 32'h0000_0000;
      end else if (S_AXI_ARADDR == `WD_OFS_SYSCFG) begin
         rd_word[`WD_PT_HI_BIT] = tprescale_q[1];
         rd_word[`WD_PT_LO_BIT] = tprescale_q[0];
      end else if (S_AXI_ARADDR == `WD_OFS_STATUS) begin
         // Counter is observable but never writable
         rd_word[7:0] = count_q;
         rd_word[15:8] = pend_ctrl_q;
         rd_word[16] = feed_armed_q;
      end else begin
         rd_ok = 1'b0;
      end
   end

   always @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= 2'b00;
      end else if (ar_take) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_word;
         S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: shared/wdog_defs.vh */
// Watchdog register map, field positions, reset values and feed keys.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`ifndef WDOG_DEFS_VH
`define WDOG_DEFS_VH

// Register byte offsets
`define WD_OFS_CONTROL 12'h000
`define WD_OFS_RELOAD 12'h004
`define WD_OFS_FEED1 12'h008
`define WD_OFS_FEED2 12'h00C
`define WD_OFS_SYSCFG 12'h010
`define WD_OFS_STATUS 12'h014

// Control register fields
`define WD_TAP_MSB 7
`define WD_TAP_LSB 5
`define WD_RUN_BIT 2
`define WD_TOF_BIT 1
`define WD_CONTROL_RST 8'hE4
`define WD_RELOAD_RST 8'h00

// System configuration fields (timer prescale)
`define WD_PT_HI_BIT 3
`define WD_PT_LO_BIT 2
`define WD_SYSCFG_RST 8'h00

// Feed keys
`define WD_FEED1_KEY 8'hA5
`define WD_FEED2_KEY 8'h5A

// Prescaler geometry
`define WD_PRESC_W 13
`define WD_TAP_BASE 4
`define WD_TBASE_DIV4 6'd3
`define WD_TBASE_DIV16 6'd15
`define WD_TBASE_DIV64 6'd63

// Reset request pulse length in clocks
`define WD_RST_PULSE 4'd4

`endif

/* File: src/wdog_tick_div.v */
// Timer base clock divider: produces one-cycle enables at osc/4, /16 or /64.
// Assumes the oscillator is the module clock; code 11 is reserved and stops ticks.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defs.vh"

module wdog_tick_div (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Control
   input wire [1:0] prescale_sel,
   // Tick out
   output reg tick
);
   reg [5:0] cnt_q;
   reg [5:0] limit;

   always @* begin
      case (prescale_sel)
         2'b00: limit = `WD_TBASE_DIV4;
         2'b01: limit = `WD_TBASE_DIV16;
         2'b10: limit = `WD_TBASE_DIV64;
         default: limit = 6'h3F;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 6'h00;
         tick <= 1'b0;
      end else if (prescale_sel == 2'b11) begin
         // Reserved setting: hold the base clock still
         cnt_q <= 6'h00;
         tick <= 1'b0;
      end else if (cnt_q >= limit) begin
         cnt_q <= 6'h00;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 6'd1;
         tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: bench/watchdog_timer_properties.sv */
// Checker for the watchdog bus handshakes, feed faults and reset request.
// Assumes feed writes offer address and data together.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_properties (
   // Clock and reset
   input wire CLK,
   input wire RST_N,
   // Register bus
   input wire [11:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire [1:0] S_AXI_BRESP,
   input wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Reset request
   input wire WDOG_RESET_REQ
);
   wire aw_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   wire ar_go = S_AXI_ARVALID && S_AXI_ARREADY;
   wire key2 = S_AXI_AWADDR == 12'h00C && S_AXI_WDATA[7:0] == 8'h5A;
   reg armed_q;
   // Split address/data writes are not tracked; they leave the guess unchanged
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N)
         armed_q <= 1'b0;
      else if (aw_go || ar_go)
         armed_q <= aw_go && S_AXI_AWADDR == 12'h008 && S_AXI_WDATA[7:0] == 8'hA5;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   pulse_width_a: assert property ($rose(WDOG_RESET_REQ) |-> WDOG_RESET_REQ [*4])
      else $error("reset pulse short");
   bad_value_a: assert property (armed_q && aw_go && !key2 |-> ##[1:2] WDOG_RESET_REQ)
      else $error("bad feed ignored");
   read_break_a: assert property (armed_q && ar_go |-> ##[1:2] WDOG_RESET_REQ)
      else $error("read in feed ignored");
   bresp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");
   read_answer_a: assert property (ar_go |=> S_AXI_RVALID)
      else $error("read not answered");
   write_answer_a: assert property (aw_go |=> S_AXI_BVALID && !S_AXI_AWREADY)
      else $error("write not answered");
   unmapped_write_a: assert property (aw_go && S_AXI_AWADDR > 12'h014 |=> S_AXI_BRESP == 2'b10)
      else $error("unmapped write accepted");
endmodule
bind watchdog_timer watchdog_timer_properties u_props (.CLK(CLK), .RST_N(RST_N),
   .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .WDOG_RESET_REQ(WDOG_RESET_REQ));
`default_nettype wire

/* File: bench/tb.sv */
// Bench for the watchdog: bus tasks, feeds, timeouts and resets.
// Assumes the reset request is only observed, never fed back.
`timescale 1ns/1ps
`default_nettype none
module tb;
   reg CLK = 1'b0;
   reg RST_N = 1'b0;
   reg awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   reg [11:0] aa = 12'h000, ra = 12'h000;
   reg [31:0] wd = 32'h0000_0000, seed = 32'hba2a_9064;
   wire awr, wrdy, bv, arr, rv, req;
   wire [1:0] bresp, rresp;
   wire [31:0] rd;
   reg [33:0] q[$];
   integer num_errors = 0, n_checks = 0, reqs = 0, n, k, t;
   always #2.5 CLK = ~CLK;
   watchdog_timer u_dut (.CLK(CLK), .RST_N(RST_N), .S_AXI_AWADDR(aa), .S_AXI_AWPROT(3'h0),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(ra), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rr), .WDOG_RESET_REQ(req));
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   task chk(input [33:0] got, input [33:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [11:0] a, input [31:0] d, input [1:0] e);
      begin
         q.push_back({e, 32'h0000_0000});
         @(posedge CLK);
         aa <= a;
         wd <= d;
         awv <= 1'b1;
         wv <= 1'b1;
         br <= 1'b1;
         // The loop test sees the levels driven before this edge, so the body runs at least twice
         do begin
            @(posedge CLK);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) br <= 1'b0;
         end while (awv || wv || br);
      end
   endtask
   task rdr(input [11:0] a, input [31:0] e);
      begin
         q.push_back({2'b00, e});
         @(posedge CLK);
         ra <= a;
         arv <= 1'b1;
         rr <= 1'b1;
         do begin
            @(posedge CLK);
            if (arr) arv <= 1'b0;
            if (rv) rr <= 1'b0;
         end while (arv || rr);
      end
   endtask
   task feed;
      begin
         wr(12'h008, 32'hA5, 2'b00);
         wr(12'h00C, 32'h5A, 2'b00);
      end
   endtask
   // Base divider phase is not cleared by a feed, so up to one base period d early
   task meas(input integer e, input integer d);
      begin
         n = 0;
         k = reqs;
         while (reqs == k && n < 20000) begin
            @(posedge CLK);
            n = n + 1;
         end
         chk(n > e - d - 8 && n < e + 8, 1);
      end
   endtask
   task tmo(input [1:0] s, input [2:0] p, input [7:0] w, input integer e);
      begin
         wr(12'h010, {28'h0, s, 2'b00}, 2'b00);
         wr(12'h000, {24'h0, p, 5'b00100}, 2'b00);
         wr(12'h004, {24'h0, w}, 2'b00);
         feed;
         meas(e, 4 << (2 * s));
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d errors %0d", n_checks, num_errors);
         if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   always @(posedge req) reqs = reqs + 1;
   always @(posedge CLK) begin
      if (bv && br) chk({bresp, 32'h0000_0000}, q.pop_front());
      if (rv && rr) chk({rresp, rd}, q.pop_front());
   end
   // Longest path is about 56000 clocks
   initial begin
      #400000;
      num_errors = num_errors + 1;
      stop_test;
   end
   initial begin
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CLK);
      rdr(12'h000, 32'hE4);
      rdr(12'h004, 32'h00);
      rdr(12'h00C, 32'h00);
      wr(12'h020, 32'h1, 2'b10);
      for (t = 0; t < 5; t = t + 1) begin
         seed = xs(seed);
         if (t == 4) seed[7:0] = 8'hFF;
         wr(12'h004, seed & 32'hFF, 2'b00);
         rdr(12'h004, seed & 32'hFF);
      end
      $display("end registers");
      wr(12'h000, 32'h24, 2'b00);
      rdr(12'h000, 32'hE4);
      feed;
      rdr(12'h000, 32'h24);
      $display("end pending");
      for (t = 0; t < 8; t = t + 1) tmo(2'd0, t[2:0], 8'h00, 128 << t);
      tmo(2'd1, 3'd0, 8'h02, 1536);
      tmo(2'd2, 3'd0, 8'h00, 2048);
      rdr(12'h000, 32'h06);
      rdr(12'h004, 32'h00);
      wr(12'h000, 32'h04, 2'b00);
      rdr(12'h000, 32'h04);
      $display("end timeouts");
      wr(12'h000, 32'h00, 2'b00);
      feed;
      k = reqs;
      repeat (3000) @(posedge CLK);
      chk(reqs == k, 1);
      wr(12'h008, 32'hA5, 2'b00);
      wr(12'h00C, 32'h5B, 2'b00);
      repeat (8) @(posedge CLK);
      chk(reqs == k + 1, 1);
      wr(12'h008, 32'hA5, 2'b00);
      rdr(12'h000, 32'h00);
      repeat (8) @(posedge CLK);
      chk(reqs == k + 2, 1);
      $display("end feed faults");
      RST_N <= 1'b0;
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CLK);
      rdr(12'h000, 32'hE4);
      meas(16384, 4);
      $display("end external reset");
      stop_test;
   end
endmodule
`default_nettype wire
